// *** fmd_ack_model.sv ***
// Purpose: Software acknowledging interrupts. Assumes: pulses. Notes: slow adds a cycle.
`timescale 1ns/1ps
module fmd_ack_model #(
  parameter int N = 20
) (
  input  wire logic         clk,  // Clock.
  input  wire logic         en,   // Acknowledge at all.
  input  wire logic         slow, // Extra cycle of delay.
  input  wire logic [N-1:0] irq,  // Interrupts.
  output logic      [N-1:0] ack   // Acknowledges.
);
  logic [N-1:0] irq_d_r;
  initial ack = '0;
  always @(posedge clk) begin
    irq_d_r <= irq;
    ack     <= en ? (slow ? irq_d_r : irq) : '0;
  end
endmodule

// *** fmd_lost_flag.sv ***
// Purpose: Bank of lost-interrupt flags, one per interrupt source.
// Assumes: Request, acknowledge and clear are one-cycle pulses per bit.
// Notes:   A lost request beside a clear of the same flag keeps the flag set.
`timescale 1ns/1ps
module fmd_lost_flag #(
  parameter int N = 4
) (
  input  wire logic         clk,     // System clock.
  input  wire logic         rst_n,   // Synchronised reset, active low.
  input  wire logic [N-1:0] irq,     // New process interrupt per source.
  input  wire logic [N-1:0] ack,     // Acknowledge of the outstanding interrupt.
  input  wire logic [N-1:0] clr,     // Clear of the lost flag.
  output logic      [N-1:0] lost     // Lost-interrupt flags.
);
  logic [N-1:0] pend_r;
  logic [N-1:0] pend_nxt;
  logic [N-1:0] lost_nxt;
  wire  [N-1:0] set_w;

  // An acknowledge in the same cycle as the new request frees the slot in time.
  assign set_w    = irq & pend_r & ~ack;
  assign pend_nxt = irq | (pend_r & ~ack);
  assign lost_nxt = set_w | (lost & ~clr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= '0;
      lost   <= '0;
    end else begin
      pend_r <= pend_nxt;
      lost   <= lost_nxt;
    end
  end
endmodule

// *** fmd_pkg.sv ***
// Purpose: Constants for the frequency measurement diagnostic record.
// Assumes: Byte-wide register port, record bytes at addresses 0 to 15.
// Notes:   Addresses 10h and 11h hold the control and summary registers.
//
// Overview of operation
// - Record is 16 bytes: basic record in bytes 0-3, twelve specific bytes.
// - Byte 4 bits 6..0 hold channel type code, digital input 70h.
// - Byte 4 bit 7 says whether more channel types follow.
// - Byte 5 reads diagnostic bits per channel, constant 08h.
// - Byte 6 reads number of channels, constant 08h.
// - Byte 7 bits 0-3 flag errors of the four input groups.
// - Byte 7 bits 4-7 flag errors of frequency meters 0 to 3.
// - Bytes 8-11 flag lost interrupts of 16 inputs at even bits.
// - Byte 12 bit 0 flags lost end-of-integration interrupt, meter 0.
// - Bytes 13-15 bit 0 flag lost end-of-integration, meters 1 to 3.
package fmd_pkg;
  localparam int        ADDR_W          = 5;
  localparam int        DATA_W          = 8;
  localparam int        REC_BYTES       = 16;
  localparam int        BASIC_BYTES     = 4;
  localparam int        DI_NUM          = 16;
  localparam int        MEAS_NUM        = 4;
  localparam int        GRP_NUM         = 4;
  localparam int        DI_PER_BYTE     = 4;

  localparam logic [4:0] OFS_BASIC      = 5'h00;
  localparam logic [4:0] OFS_CHTYPE     = 5'h04;
  localparam logic [4:0] OFS_DIAG_BITS  = 5'h05;
  localparam logic [4:0] OFS_CHAN_NUM   = 5'h06;
  localparam logic [4:0] OFS_GRP_ERR    = 5'h07;
  localparam logic [4:0] OFS_DI_LOST    = 5'h08;
  localparam logic [4:0] OFS_MEAS_LOST  = 5'h0C;
  localparam logic [4:0] OFS_CTRL       = 5'h10;
  localparam logic [4:0] OFS_SUMMARY    = 5'h11;

  localparam logic [6:0] CHTYPE_DIG_IN  = 7'h70;
  localparam logic [6:0] CHTYPE_ANA_IN  = 7'h71;
  localparam logic [6:0] CHTYPE_DIG_OUT = 7'h72;
  localparam logic [6:0] CHTYPE_ANA_OUT = 7'h73;
  localparam logic [6:0] CHTYPE_ANA_IO  = 7'h74;
  localparam logic [7:0] DIAG_BITS_VAL  = 8'h08;
  localparam logic [7:0] CHAN_NUM_VAL   = 8'h08;

  localparam int        CTRL_CLR_ALL    = 0;
  localparam int        CTRL_RD_CLR     = 1;
  localparam logic [1:0] CTRL_RST       = 2'h2;
  localparam int        SUM_DI_LOST     = 0;
  localparam int        SUM_MEAS_LOST   = 1;
  localparam int        SUM_ANY_ERR     = 2;
endpackage

// *** fmd_record.sv ***
// Purpose: Diagnostic record of the integrated inputs in frequency measurement mode.
// Assumes: Inputs are synchronous to clk; the basic record is supplied from outside.
// Notes:   Read data appear one cycle after the read strobe and only then.
`timescale 1ns/1ps
module fmd_record #(
  parameter int DI_N   = fmd_pkg::DI_NUM,
  parameter int MEAS_N = fmd_pkg::MEAS_NUM
) (
  input  wire logic                        clk,          // 40 MHz system clock.
  input  wire logic                        rst_n,        // Asynchronous reset, active low.
  input  wire logic [31:0]                 basic_rec,    // Basic record, byte 0 in bits 7:0.
  input  wire logic                        more_types,   // Further channel types follow.
  input  wire logic [fmd_pkg::GRP_NUM-1:0] grp_err,      // Error per input group.
  input  wire logic [MEAS_N-1:0]           meter_err,    // Error per frequency meter.
  input  wire logic [DI_N-1:0]             di_irq,       // Input process interrupt pulse.
  input  wire logic [DI_N-1:0]             di_ack,       // Input interrupt acknowledge.
  input  wire logic [MEAS_N-1:0]           meas_irq,     // End of integration time pulse.
  input  wire logic [MEAS_N-1:0]           meas_ack,     // End of integration acknowledge.
  input  wire logic [fmd_pkg::ADDR_W-1:0]  addr,         // Register address.
  input  wire logic [fmd_pkg::DATA_W-1:0]  wdata,        // Write data.
  input  wire logic                        wr,           // Write strobe.
  input  wire logic                        rd,           // Read strobe.
  output logic      [fmd_pkg::DATA_W-1:0]  rdata,        // Read data, one cycle after rd.
  output logic                             lost_any      // Some lost flag is set.
);
  logic                           rst_s1_r;
  logic                           rst_s2_r;
  logic [fmd_pkg::GRP_NUM-1:0]    grp_err_r;
  logic [MEAS_N-1:0]              meter_err_r;
  logic [31:0]                    basic_r;
  logic                           more_r;
  logic                           rd_clr_en_r;
  logic                           rd_clr_en_nxt;
  logic [fmd_pkg::DATA_W-1:0]     rdata_nxt;
  logic [DI_N-1:0]                di_lost;
  logic [MEAS_N-1:0]              meas_lost;
  logic [DI_N-1:0]                di_clr;
  logic [MEAS_N-1:0]              meas_clr;
  logic [8*fmd_pkg::REC_BYTES-1:0] rec_w;

  // The rest of the design sees only the synchronised copy of the reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  wire rstn_w = rst_s2_r;

  // Address decode.
  wire in_rec_w   = (addr < 5'(fmd_pkg::REC_BYTES));
  wire sel_ctrl_w = (addr == fmd_pkg::OFS_CTRL);
  wire sel_sum_w  = (addr == fmd_pkg::OFS_SUMMARY);
  wire sel_di_w   = (addr >= fmd_pkg::OFS_DI_LOST) && (addr < fmd_pkg::OFS_MEAS_LOST);
  wire sel_meas_w = (addr >= fmd_pkg::OFS_MEAS_LOST) && in_rec_w;
  wire [1:0] di_byte_w   = 2'(addr - fmd_pkg::OFS_DI_LOST);
  wire [1:0] meas_byte_w = 2'(addr - fmd_pkg::OFS_MEAS_LOST);

  wire wr_clr_all_w = wr && sel_ctrl_w && wdata[fmd_pkg::CTRL_CLR_ALL];
  wire rd_clr_w     = rd && rd_clr_en_r;

  assign rd_clr_en_nxt = (wr && sel_ctrl_w) ? wdata[fmd_pkg::CTRL_RD_CLR] : rd_clr_en_r;

  // Lost flags clear by reading their byte while read-clear is enabled, by writing ones to it, or by clear-all.
  genvar gi;
  generate
    for (gi = 0; gi < DI_N; gi++) begin : g_di_clr
      assign di_clr[gi] = wr_clr_all_w ||
        (sel_di_w && (di_byte_w == 2'(gi / fmd_pkg::DI_PER_BYTE)) &&
         (rd_clr_w || (wr && wdata[2*(gi % fmd_pkg::DI_PER_BYTE)])));
    end
    for (gi = 0; gi < MEAS_N; gi++) begin : g_meas_clr
      assign meas_clr[gi] = wr_clr_all_w ||
        (sel_meas_w && (meas_byte_w == 2'(gi)) && (rd_clr_w || (wr && wdata[0])));
    end
  endgenerate

  fmd_lost_flag #(
    .N     (DI_N)
  ) u_di_lost (
    .clk   (clk),
    .rst_n (rstn_w),
    .irq   (di_irq),
    .ack   (di_ack),
    .clr   (di_clr),
    .lost  (di_lost)
  );

  fmd_lost_flag #(
    .N     (MEAS_N)
  ) u_meas_lost (
    .clk   (clk),
    .rst_n (rstn_w),
    .irq   (meas_irq),
    .ack   (meas_ack),
    .clr   (meas_clr),
    .lost  (meas_lost)
  );

  // Record image, byte n in bits 8n+7 to 8n.
  assign rec_w[31:0]  = basic_r;
  assign rec_w[38:32] = fmd_pkg::CHTYPE_DIG_IN;
  assign rec_w[39]    = more_r;
  assign rec_w[47:40] = fmd_pkg::DIAG_BITS_VAL;
  assign rec_w[55:48] = fmd_pkg::CHAN_NUM_VAL;
  assign rec_w[59:56] = grp_err_r;
  assign rec_w[63:60] = meter_err_r;

  generate
    for (gi = 0; gi < DI_N; gi++) begin : g_di_bits
      assign rec_w[64 + 2*gi]     = di_lost[gi];
      assign rec_w[64 + 2*gi + 1] = 1'b0;
    end
    for (gi = 0; gi < MEAS_N; gi++) begin : g_meas_bits
      assign rec_w[96 + 8*gi]            = meas_lost[gi];
      assign rec_w[96 + 8*gi + 7 -: 7]   = 7'h00;
    end
  endgenerate

  wire [fmd_pkg::DATA_W-1:0] rec_byte_w = rec_w[8*addr[3:0] +: 8];
  wire [fmd_pkg::DATA_W-1:0] ctrl_w     = {6'h00, rd_clr_en_r, 1'b0};
  wire [fmd_pkg::DATA_W-1:0] sum_w      = {5'h00, (|grp_err_r) | (|meter_err_r),
                                           |meas_lost, |di_lost};

  // Unmapped addresses and idle cycles read as zero.
  assign rdata_nxt = !rd        ? 8'h00 :
                     in_rec_w   ? rec_byte_w :
                     sel_ctrl_w ? ctrl_w :
                     sel_sum_w  ? sum_w : 8'h00;

  always_ff @(posedge clk or negedge rstn_w) begin
    if (!rstn_w) begin
      grp_err_r   <= '0;
      meter_err_r <= '0;
      basic_r     <= 32'h0000_0000;
      more_r      <= 1'b0;
      rd_clr_en_r <= fmd_pkg::CTRL_RST[fmd_pkg::CTRL_RD_CLR];
      rdata       <= 8'h00;
      lost_any    <= 1'b0;
    end else begin
      grp_err_r   <= grp_err;
      meter_err_r <= meter_err;
      basic_r     <= basic_rec;
      more_r      <= more_types;
      rd_clr_en_r <= rd_clr_en_nxt;
      rdata       <= rdata_nxt;
      lost_any    <= (|di_lost) | (|meas_lost);
    end
  end
endmodule

// *** fmd_record_checker.sv ***
// Purpose: Port checks. Assumes: one-cycle read. Notes: bound below.
`timescale 1ns/1ps
module fmd_record_checker #(
  parameter int DI_N   = 16,
  parameter int MEAS_N = 4
) (
  input wire logic              clk,        // Clock.
  input wire logic              rst_n,      // Reset.
  input wire logic              more_types, // Type flag.
  input wire logic [3:0]        grp_err,    // Groups.
  input wire logic [MEAS_N-1:0] meter_err,  // Meters.
  input wire logic [DI_N-1:0]   di_irq,     // Interrupts.
  input wire logic [DI_N-1:0]   di_ack,     // Acks.
  input wire logic [4:0]        addr,       // Address.
  input wire logic              rd,         // Read.
  input wire logic [7:0]        rdata       // Data.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_lost3;
    di_irq[3] ##1 (di_irq[3] && !di_ack[3]) ##1 (rd && addr == 5'h08);
  endsequence
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("rdata outside read");
  a_type_code: assert property (rd && addr == 5'h04 |=> rdata[6:0] == 7'h70)
    else $error("type code");
  a_more_bit: assert property (rd && addr == 5'h04 && $stable(more_types)
    |=> rdata[7] == $past(more_types)) else $error("more bit");
  a_diag_bits: assert property (rd && addr == 5'h05 |=> rdata == 8'h08)
    else $error("bits per channel");
  a_chan_num: assert property (rd && addr == 5'h06 |=> rdata == 8'h08)
    else $error("channel count");
  a_grp_err: assert property (rd && addr == 5'h07
    && $stable({meter_err, grp_err}) |=> rdata == $past({meter_err, grp_err}))
    else $error("error byte");
  a_odd_zero: assert property (rd && addr[4:2] == 3'b010 |=> (rdata & 8'hAA) == 8'h00)
    else $error("odd bit set");
  a_meas_hi: assert property (rd && addr[4:2] == 3'b011
    |=> rdata[7:1] == 7'h00) else $error("meter byte high bits");
  a_lost_seen: assert property (s_lost3 |=> rdata[6])
    else $error("lost flag missing");
  a_unmapped_zero: assert property (rd && addr >= 5'h12 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind fmd_record fmd_record_checker #(.DI_N(DI_N), .MEAS_N(MEAS_N)) u_chk (.clk(clk),
  .rst_n(rst_n), .more_types(more_types), .grp_err(grp_err), .meter_err(meter_err),
  .di_irq(di_irq), .di_ack(di_ack), .addr(addr), .rd(rd), .rdata(rdata));

// *** fmd_record_tb.sv ***
// Purpose: Bench for fmd_record. Assumes: 40 MHz. Notes: fixed seed.
`timescale 1ns/1ps
module fmd_record_tb;
  logic        clk, rst_n, more_types, wr, rd, en, slow, lost_any;
  logic [31:0] basic_rec, seed;
  logic [3:0]  grp_err, meter_err;
  logic [19:0] irq_v, ack_v;
  logic [4:0]  addr;
  logic [7:0]  wdata, rdata;
  int          error_cnt, num_checks, cyc, j;
  fmd_record dut (.clk(clk), .rst_n(rst_n), .basic_rec(basic_rec), .more_types(more_types),
    .grp_err(grp_err), .meter_err(meter_err), .di_irq(irq_v[15:0]), .di_ack(ack_v[15:0]),
    .meas_irq(irq_v[19:16]), .meas_ack(ack_v[19:16]), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .lost_any(lost_any));
  fmd_ack_model #(.N(20)) u_sw (.clk(clk), .en(en), .slow(slow), .irq(irq_v), .ack(ack_v));
  always #12.5 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [4:0] lost_addr(input int i);
    return (i < 16) ? 5'(8 + i / 4) : 5'(i - 4);
  endfunction
  function automatic logic [7:0] lost_mask(input int i);
    return (i < 16) ? 8'(1 << (2 * (i % 4))) : 8'h01;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    addr  <= a;
    rd    <= 1'b1;
    irq_v <= '0;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  task automatic wr_t(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Two back-to-back requests with acknowledge off, so the second one is lost.
  task automatic lose(input int i);
    @(posedge clk);
    en    <= 1'b0;
    irq_v <= 20'(1) << i;
    repeat (2) @(posedge clk);
    irq_v <= '0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    seed = 32'hEB21FEA1;
    {basic_rec, more_types, grp_err, meter_err, irq_v, addr, wdata, wr, rd, en, slow} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      @(posedge clk);
      basic_rec  <= seed;
      more_types <= seed[0];
      grp_err    <= seed[11:8];
      meter_err  <= seed[15:12];
      wr_t(5'h04, seed[23:16]);
      for (int b = 0; b < 4; b++) rd_chk(5'(b), seed[8*b +: 8]);
      rd_chk(5'h04, {seed[0], 7'h70});
      rd_chk(5'h05, 8'h08);
      rd_chk(5'h06, 8'h08);
      rd_chk(5'h07, seed[15:8]);
      rd_chk(5'h12 + 5'(seed[27:24] % 14), 8'h00);
    end
    $display("test record done");
    for (int i = 0; i < 20; i++) begin
      for (int k = 0; k < 3; k++) begin
        @(posedge clk);
        en    <= (k != 2);
        slow  <= (k == 1);
        irq_v <= 20'(1) << i;
        @(posedge clk);
        rd_chk(lost_addr(i), k ? lost_mask(i) : 8'h00);
        chk({7'h0, lost_any}, {7'h0, k != 0});
        rd_chk(lost_addr(i), 8'h00);
      end
    end
    $display("test lost done");
    @(posedge clk);
    grp_err   <= 4'h0;
    meter_err <= 4'h0;
    rd_chk(5'h10, 8'h02);
    rd_chk(5'h11, 8'h00);
    for (int n = 0; n < 6; n++) begin
      seed = xs(seed);
      j = int'(seed[7:0]) % 20;
      wr_t(5'h10, 8'h00);
      lose(j);
      rd_chk(lost_addr(j), lost_mask(j));
      rd_chk(lost_addr(j), lost_mask(j));
      rd_chk(5'h11, (j < 16) ? 8'h01 : 8'h02);
      wr_t(lost_addr(j), lost_mask(j) | (seed[15:8] & 8'hAA));
      rd_chk(lost_addr(j), 8'h00);
      wr_t(5'h10, 8'h02);
      @(posedge clk);
      addr  <= lost_addr(j);
      rd    <= 1'b1;
      irq_v <= 20'(1) << j;
      @(posedge clk);
      rd    <= 1'b0;
      irq_v <= '0;
      @(negedge clk);
      chk(rdata, 8'h00);
      rd_chk(lost_addr(j), lost_mask(j));
      rd_chk(lost_addr(j), 8'h00);
    end
    wr_t(5'h10, 8'h00);
    lose(0);
    lose(19);
    rd_chk(5'h11, 8'h03);
    chk({7'h0, lost_any}, 8'h01);
    wr_t(5'h10, 8'h03);
    rd_chk(5'h10, 8'h02);
    chk({7'h0, lost_any}, 8'h00);
    rd_chk(5'h08, 8'h00);
    rd_chk(5'h0F, 8'h00);
    @(posedge clk);
    grp_err <= 4'h4;
    rd_chk(5'h11, 8'h04);
    @(posedge clk);
    grp_err   <= 4'h0;
    meter_err <= 4'h8;
    rd_chk(5'h11, 8'h04);
    wr_t(5'h10, 8'h00);
    lose(5);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(5'h10, 8'h02);
    rd_chk(lost_addr(5), 8'h00);
    chk({7'h0, lost_any}, 8'h00);
    rd_chk(5'h07, 8'h80);
    $display("test ctrl done");
    results();
  end
endmodule
